// *** psp_core.sv ***
// Process-loop core: source selection, error, proportional and integral terms
`timescale 1ns/1ps
`include "psp_defines.svh"

// Summary of operation
// [RL1] Setpoint codes 4,5,7,9,11: second analog, RS-485, fieldbus, user sequence, pulse.
// [RL2] Second analog reads 4-20 mA in current mode, 0-10 V in voltage mode.
// [RL3] Pulse source is the edge rate of the pulse pin, 0 to 32 kHz.
// [RL4] Feedback accepts the setpoint codes except both keypad entries.
// [RL5] Feedback source may never equal the active setpoint source.
// [RL6] Proportional term is error times gain percent, 0.0 to 1000 percent.
// [RL7] A fine-scale percent further scales the proportional gain.
// [RL8] Constant full error gives full integral output after the integral time.
// [RL9] Integral clear function code 21 active zeroes the accumulator.
// [RL10] Monitor code 17 shows setpoint, code 18 shows feedback.
// [RL11] Code 0 is keypad value, code 1 the bipolar ten-volt first analog.
// [RL12] Keypad setpoint value is used only while keypad is the source.
// [RL13] Inputs sampled and terms updated once per tick; output is their sum. Integral clear also zeroes the integral term between ticks.
// [RL14] Accumulator saturates rather than wraps and clears on reset.
module psp_core #(
  parameter int TICK_CYCLES = `PSP_TICK_CYC,
  parameter int GATE_CYCLES = `PSP_GATE_CYC
) (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire psp_pkg::psp_code_t setpoint_source_select,
  input  wire psp_pkg::psp_code_t feedback_source_select,
  input  wire psp_pkg::psp_val_t keypad_setpoint,
  input  wire logic signed [11:0] first_analog_voltage_input,
  input  wire logic        [11:0] second_analog_input,
  input  wire logic              current_voltage_select_switch,
  input  wire psp_pkg::psp_val_t rs485_value,
  input  wire psp_pkg::psp_val_t fieldbus_value,
  input  wire psp_pkg::psp_val_t user_sequence_link,
  input  wire logic              pulse_train_input,
  input  wire logic        [13:0] proportional_gain,
  input  wire logic        [9:0]  proportional_gain_scale,
  input  wire logic        [15:0] integral_time,
  input  wire psp_pkg::psp_code_t multi_function_code,
  input  wire logic              multi_function_input,
  input  wire psp_pkg::psp_code_t monitor_select,
  output psp_pkg::psp_val_t      setpoint_value,
  output psp_pkg::psp_val_t      feedback_value,
  output psp_pkg::psp_val_t      proportional_term,
  output psp_pkg::psp_val_t      integral_term,
  output psp_pkg::psp_val_t      controller_output,
  output psp_pkg::psp_val_t      monitor_value,
  output psp_pkg::psp_code_t     active_setpoint_source,
  output psp_pkg::psp_code_t     active_feedback_source,
  output logic                   source_select_refused
);
  // ********************************************************
  // Reset release and pin synchronisers
  // ********************************************************
  logic       rst_ff1_reg;
  logic       rst_n;
  logic [2:0] pin_raw;
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [2:0] pin_s3_reg;
  logic [2:0] pin_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_ff1_reg <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_ff1_reg <= 1'b1;
      rst_n       <= rst_ff1_reg;
    end
  end
  assign pin_raw = {multi_function_input, current_voltage_select_switch, pulse_train_input};
  // Change accepted only once two late stages agree, so one glitch is dropped
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1_reg[gi] <= 1'b0;
          pin_s2_reg[gi] <= 1'b0;
          pin_s3_reg[gi] <= 1'b0;
          pin_reg[gi]    <= 1'b0;
        end else begin
          pin_s1_reg[gi] <= pin_raw[gi];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
          pin_s3_reg[gi] <= pin_s2_reg[gi];
          if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
            pin_reg[gi] <= pin_s3_reg[gi];
          end
        end
      end
    end
  endgenerate
  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic psp_pkg::psp_val_t sat16(input logic signed [47:0] x);
    if (x > 48'(`PSP_VMAX)) begin
      sat16 = 16'sh7FFF;
    end else if (x < 48'(`PSP_VMIN)) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = x[15:0];
    end
  endfunction
  logic              clr_i;
  logic signed [47:0] a1_wide;
  logic signed [47:0] a2_wide;
  logic signed [47:0] a2_ofs;
  psp_pkg::psp_val_t a1_val;
  psp_pkg::psp_val_t a2_val;
  assign clr_i   = pin_reg[2] && (multi_function_code == `PSP_MFI_ICLR);
  assign a1_wide = 48'(first_analog_voltage_input) * 48'(`PSP_FULL) / 48'(`PSP_A1_FS);
  assign a2_ofs  = $signed(48'(second_analog_input)) - 48'(`PSP_A2_4MA);
  // Current below 4 mA reads as zero rather than negative
  always_comb begin
    if (pin_reg[1]) begin
      a2_wide = (a2_ofs < 48'sh0) ? 48'sh0 :
                a2_ofs * 48'(`PSP_FULL) / 48'(`PSP_A2_ISPAN); // RL2
    end else begin
      a2_wide = $signed(48'(second_analog_input)) * 48'(`PSP_FULL)
                / 48'(`PSP_A2_VFS); // RL2
    end
  end
  assign a1_val = sat16(a1_wide); // RL11
  assign a2_val = sat16(a2_wide);
  // ********************************************************
  // Control tick and pulse rate gate
  // ********************************************************
  logic [31:0]       tick_cnt_reg;
  logic              tick;
  logic [31:0]       gate_cnt_reg;
  logic [15:0]       edge_cnt_reg;
  logic              pulse_prev_reg;
  psp_pkg::psp_val_t pulse_val_reg;
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 32'h00000000;
    end else if (tick) begin
      tick_cnt_reg <= 32'h00000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end
  end
  // Rate resolution is one edge per gate, traded for a simple counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gate_cnt_reg   <= 32'h00000000;
      edge_cnt_reg   <= 16'h0000;
      pulse_prev_reg <= 1'b0;
      pulse_val_reg  <= 16'sh0000;
    end else begin
      pulse_prev_reg <= pin_reg[0];
      if (gate_cnt_reg == 32'(GATE_CYCLES - 1)) begin
        gate_cnt_reg  <= 32'h00000000;
        edge_cnt_reg  <= 16'h0000;
        pulse_val_reg <= sat16($signed(48'(edge_cnt_reg)) * 48'(`PSP_FULL)
                               / 48'(`PSP_PULSE_FULL)); // RL3
      end else begin
        gate_cnt_reg <= gate_cnt_reg + 32'h00000001;
        if (pin_reg[0] && !pulse_prev_reg && edge_cnt_reg != 16'hFFFF) begin
          edge_cnt_reg <= edge_cnt_reg + 16'h0001; // RL3
        end
      end
    end
  end

  // ********************************************************
  // Source selection
  // ********************************************************
  function automatic logic known_src(input psp_pkg::psp_code_t c);
    case (c)
      `PSP_SRC_KEYPAD, `PSP_SRC_KEYPAD2, `PSP_SRC_A1, `PSP_SRC_A2,
      `PSP_SRC_RS485, `PSP_SRC_FBUS, `PSP_SRC_USEQ,
      `PSP_SRC_PULSE: known_src = 1'b1;
      default:        known_src = 1'b0;
    endcase
  endfunction
  function automatic psp_pkg::psp_val_t pick(input psp_pkg::psp_code_t c);
    case (c)
      `PSP_SRC_KEYPAD, `PSP_SRC_KEYPAD2: pick = keypad_setpoint; // RL12
      `PSP_SRC_A1:    pick = a1_val;             // RL11
      `PSP_SRC_A2:    pick = a2_val;             // RL1
      `PSP_SRC_RS485: pick = rs485_value;        // RL1
      `PSP_SRC_FBUS:  pick = fieldbus_value;     // RL1
      `PSP_SRC_USEQ:  pick = user_sequence_link; // RL1
      `PSP_SRC_PULSE: pick = pulse_val_reg;      // RL1
      default:        pick = 16'sh0000;
    endcase
  endfunction
  logic               sp_ok;
  logic               fb_ok;
  psp_pkg::psp_code_t sp_after;
  assign sp_ok    = known_src(setpoint_source_select) &&
                    (setpoint_source_select != active_feedback_source); // RL5
  assign sp_after = sp_ok ? setpoint_source_select : active_setpoint_source;
  // Refused request leaves the previous source in force
  assign fb_ok    = known_src(feedback_source_select) &&
                    (feedback_source_select != `PSP_SRC_KEYPAD) &&
                    (feedback_source_select != `PSP_SRC_KEYPAD2) && // RL4
                    (feedback_source_select != sp_after); // RL5
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_setpoint_source <= `PSP_SP_RESET;
      active_feedback_source <= `PSP_FB_RESET;
      source_select_refused  <= 1'b0;
    end else begin
      if (sp_ok) begin
        active_setpoint_source <= setpoint_source_select;
      end
      if (fb_ok) begin
        active_feedback_source <= feedback_source_select;
      end
      source_select_refused <= !sp_ok || !fb_ok;
    end
  end

  // ********************************************************
  // PI arithmetic
  // ********************************************************
  logic signed [47:0] err_w;
  logic signed [47:0] p_w;
  logic signed [47:0] n_ticks;
  logic signed [40:0] acc_sum;
  psp_pkg::psp_acc_t  acc_reg;
  psp_pkg::psp_acc_t  acc_next;
  psp_pkg::psp_val_t  p_next;
  psp_pkg::psp_val_t  i_next;
  assign err_w   = 48'(setpoint_value) - 48'(feedback_value);
  assign p_w     = err_w * $signed(48'(proportional_gain))
                   * $signed(48'(proportional_gain_scale)) / 48'(`PSP_P_DIV); // RL6 RL7
  assign p_next  = sat16(p_w);
  assign n_ticks = $signed(48'(integral_time)) * 48'(`PSP_IT_TICKS);
  assign acc_sum = 41'(acc_reg) + 41'(err_w);
  always_comb begin
    if (clr_i || integral_time == 16'h0000) begin
      acc_next = 40'sh0; // RL9
    end else if (acc_sum > `PSP_ACC_MAX) begin
      acc_next = 40'sh7FFFFFFFFF; // RL14
    end else if (acc_sum < `PSP_ACC_MIN) begin
      acc_next = 40'sh8000000001; // RL14
    end else begin
      acc_next = acc_sum[39:0]; // RL8
    end
  end
  // Zero integral time disables the term instead of dividing by zero
  assign i_next = (n_ticks == 48'sh0) ? 16'sh0000 :
                  sat16(48'(acc_next) / n_ticks); // RL8
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= 40'sh0; // RL14
    end else if (clr_i) begin
      acc_reg <= 40'sh0; // RL9
    end else if (tick) begin
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      setpoint_value    <= 16'sh0000;
      feedback_value    <= 16'sh0000;
      proportional_term <= 16'sh0000;
      integral_term     <= 16'sh0000;
      controller_output <= 16'sh0000;
    end else begin
      if (clr_i) begin
        integral_term <= 16'sh0000; // RL9
      end
      if (tick) begin
        setpoint_value    <= pick(active_setpoint_source); // RL13
        feedback_value    <= pick(active_feedback_source); // RL13
        proportional_term <= p_next;
        integral_term     <= i_next;
        controller_output <= sat16(48'(p_next) + 48'(i_next)); // RL13
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      monitor_value <= 16'sh0000;
    end else if (monitor_select == `PSP_MON_SP) begin
      monitor_value <= setpoint_value; // RL10
    end else if (monitor_select == `PSP_MON_FB) begin
      monitor_value <= feedback_value; // RL10
    end else begin
      monitor_value <= 16'sh0000;
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_mon_sp;
    monitor_select == `PSP_MON_SP ##1 monitor_select == `PSP_MON_SP;
  endsequence
  sequence s_mon_fb;
    monitor_select == `PSP_MON_FB ##1 monitor_select == `PSP_MON_FB;
  endsequence
  sequence s_clear_held;
    clr_i ##1 clr_i;
  endsequence
  AST_FB_NOT_KEYPAD: assert property ( // RL4
    active_feedback_source != `PSP_SRC_KEYPAD && active_feedback_source != `PSP_SRC_KEYPAD2)
    else $error("Keypad taken as feedback source");
  AST_NO_EQUAL_SRC: assert property ( // RL5
    active_feedback_source != active_setpoint_source)
    else $error("Feedback source equals setpoint source");
  AST_MON_SP: assert property (s_mon_sp |-> monitor_value == $past(setpoint_value)) // RL10
    else $error("Monitor does not show setpoint");
  AST_MON_FB: assert property (s_mon_fb |-> monitor_value == $past(feedback_value)) // RL10
    else $error("Monitor does not show feedback");
  AST_ICLEAR: assert property (s_clear_held |-> acc_reg == 40'sh0 && integral_term == 16'sh0) // RL9
    else $error("Integral not cleared");
  AST_HOLD_BETWEEN_TICKS: assert property ( // RL13
    !tick |=> $stable(setpoint_value) && $stable(proportional_term) && $stable(controller_output))
    else $error("Terms changed between ticks");
  AST_OUT_IS_SUM: assert property ( // RL13
    tick |=> controller_output == sat16(48'(proportional_term) + 48'(integral_term)))
    else $error("Output is not sum of terms");
  AST_KEYPAD_SP: assert property ( // RL12
    tick && active_setpoint_source == `PSP_SRC_KEYPAD |=> setpoint_value == $past(keypad_setpoint))
    else $error("Keypad setpoint not applied");
  AST_RS485_SP: assert property ( // RL1
    tick && active_setpoint_source == `PSP_SRC_RS485 |=> setpoint_value == $past(rs485_value))
    else $error("RS-485 setpoint not applied");
  AST_ACC_NO_WRAP: assert property ( // RL14
    tick && !clr_i && integral_time != 16'h0000 && err_w >= 48'sh0 && !$rose(clr_i)
    |=> clr_i || acc_reg >= $past(acc_reg))
    else $error("Integral accumulator wrapped");
endmodule

// *** psp_core_tb.sv ***
// Self-checking bench for the process-loop core
`timescale 1ns/1ps
module psp_core_tb;
  logic                clock = 1'b0;
  logic                resetn = 1'b0;
  psp_pkg::psp_code_t  setpoint_source_select = 8'h00;
  psp_pkg::psp_code_t  feedback_source_select = 8'h01;
  psp_pkg::psp_val_t   keypad_setpoint = 16'sh04D2;
  logic signed [11:0]  first_analog_voltage_input = 12'sh801;
  logic        [11:0]  second_analog_input = 12'h999;
  logic                current_voltage_select_switch = 1'b0;
  psp_pkg::psp_val_t   rs485_value, fieldbus_value, user_sequence_link;
  logic                pulse_train_input;
  logic        [13:0]  proportional_gain = 14'h0000;
  logic        [9:0]   proportional_gain_scale = 10'h3E8;
  logic        [15:0]  integral_time = 16'h0000;
  psp_pkg::psp_code_t  multi_function_code = 8'h00;
  logic                multi_function_input = 1'b0;
  psp_pkg::psp_code_t  monitor_select = 8'h11;
  logic        [7:0]   period = 8'h0A;
  psp_pkg::psp_val_t   setpoint_value, feedback_value, proportional_term;
  psp_pkg::psp_val_t   integral_term, controller_output, monitor_value;
  psp_pkg::psp_code_t  active_setpoint_source, active_feedback_source;
  logic                source_select_refused;
  int                  num_errors = 0;
  int                  compares = 0;
  always #2.5 clock = ~clock;
  psp_core #(.TICK_CYCLES(20), .GATE_CYCLES(200)) u_dut (
    .clock, .resetn, .setpoint_source_select, .feedback_source_select, .keypad_setpoint,
    .first_analog_voltage_input, .second_analog_input, .current_voltage_select_switch,
    .rs485_value, .fieldbus_value, .user_sequence_link, .pulse_train_input,
    .proportional_gain, .proportional_gain_scale, .integral_time, .multi_function_code,
    .multi_function_input, .monitor_select, .setpoint_value, .feedback_value,
    .proportional_term, .integral_term, .controller_output, .monitor_value,
    .active_setpoint_source, .active_feedback_source, .source_select_refused);
  psp_src_model u_src (.clock(clock), .period(period), .pulse_train_input(pulse_train_input),
    .rs485_value(rs485_value), .fieldbus_value(fieldbus_value),
    .user_sequence_link(user_sequence_link));
  // ********************************************************
  // Shared tasks
  // ********************************************************
  // Tolerance only where tick alignment is not fixed
  task automatic check(input logic signed [15:0] got, input logic signed [15:0] exp,
                       input int tol = 0);
    compares++;
    if ((^got === 1'bx) || (got > exp + tol) || (got < exp - tol)) begin
      num_errors++;
      $display("wrong value at %0t: got %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n * 20) @(negedge clock);
  endtask
  task automatic complete_run;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_reset;
    check(active_setpoint_source, 0);
    check(active_feedback_source, 1);
    check(integral_term, 0);
    check(controller_output, 0);
    $display("test reset done");
  endtask
  task automatic t_sources;
    logic [7:0]  code [6] = '{8'h00, 8'h04, 8'h05, 8'h07, 8'h09, 8'h0B};
    logic [15:0] exp [6] = '{16'h04D2, 16'h1770, 16'h0BB8, 16'h0FA0, 16'h1388, 16'h003E};
    for (int i = 0; i < 6; i++) begin
      setpoint_source_select = code[i];
      ticks(30);
      check(active_setpoint_source, code[i]);
      check(source_select_refused, 0);
      check(monitor_value, exp[i]);
    end
    current_voltage_select_switch = 1'b1;
    setpoint_source_select = 8'h04;
    ticks(4);
    check(monitor_value, 16'sh1388);
    setpoint_source_select = 8'h02;
    ticks(4);
    check(setpoint_value, 16'sh04D2);
    setpoint_source_select = 8'h05;
    keypad_setpoint = 16'sh1000;
    ticks(4);
    check(setpoint_value, 16'sh0BB8);
    $display("test sources done");
  endtask
  task automatic t_refuse;
    logic [7:0] fb [4] = '{8'h00, 8'h02, 8'h05, 8'h03};
    for (int i = 0; i < 4; i++) begin
      feedback_source_select = fb[i];
      @(negedge clock);
      @(negedge clock);
      check(active_feedback_source, 1);
      check(source_select_refused, 1);
    end
    feedback_source_select = 8'h01;
    setpoint_source_select = 8'h01;
    repeat (2) @(negedge clock);
    check(active_setpoint_source, 5);
    check(source_select_refused, 1);
    setpoint_source_select = 8'h05;
    monitor_select = 8'h12;
    ticks(4);
    check(monitor_value, -16'sd10000);
    monitor_select = 8'h13;
    repeat (2) @(negedge clock);
    check(monitor_value, 0);
    $display("test refuse done");
  endtask
  task automatic t_pterm;
    logic [13:0] g [3] = '{14'h01F4, 14'h2710, 14'h01F4};
    logic [9:0]  s [3] = '{10'h3E8, 10'h3E8, 10'h1F4};
    logic [15:0] e [3] = '{16'h01F4, 16'h2710, 16'h00FA};
    setpoint_source_select = 8'h00;
    keypad_setpoint = 16'sh0FA0;
    feedback_source_select = 8'h05;
    for (int i = 0; i < 3; i++) begin
      proportional_gain = g[i];
      proportional_gain_scale = s[i];
      ticks(5);
      check(proportional_term, e[i]);
      check(controller_output, e[i]);
      check(feedback_value, 16'sh0BB8);
    end
    $display("test pterm done");
  endtask
  task automatic t_integral;
    proportional_gain = 14'h0000;
    keypad_setpoint = 16'sh2710;
    feedback_source_select = 8'h01;
    first_analog_voltage_input = 12'sh000;
    integral_time = 16'h0001;
    multi_function_code = 8'h15;
    multi_function_input = 1'b1;
    ticks(10);
    check(integral_term, 0);
    multi_function_input = 1'b0;
    ticks(50);
    check(integral_term, 16'sd5000, 300);
    // Other code on the pin must leave the sum alone
    multi_function_code = 8'h14;
    multi_function_input = 1'b1;
    ticks(50);
    check(integral_term, 16'sd10000, 300);
    check(controller_output, 16'sd10000, 300);
    multi_function_code = 8'h15;
    ticks(2);
    check(integral_term, 0);
    $display("test integral done");
  endtask
  // ********************************************************
  // Main sequence and watchdog
  // ********************************************************
  initial begin
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    repeat (2) @(negedge clock);
    t_reset();
    t_sources();
    t_refuse();
    t_pterm();
    t_integral();
    complete_run();
  end
  // Run needs about 6500 cycles; generous margin
  initial begin
    repeat (40000) @(posedge clock);
    num_errors++;
    complete_run();
  end
endmodule

// *** psp_defines.svh ***
// Constants for the process-loop source select and PI core
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH
// ********************************************************
// Timing
// ********************************************************
`define PSP_CLK_MHZ       200
`define PSP_TICK_US       1000
`define PSP_TICK_CYC      (`PSP_TICK_US * `PSP_CLK_MHZ)
`define PSP_GATE_MS       100
`define PSP_GATE_CYC      (`PSP_GATE_MS * 1000 * `PSP_CLK_MHZ)
`define PSP_IT_UNIT_US    100000
`define PSP_IT_TICKS      32'sh00000064
// ********************************************************
// Source codes
// ********************************************************
`define PSP_SRC_KEYPAD    8'h00
`define PSP_SRC_A1        8'h01
`define PSP_SRC_KEYPAD2   8'h02
`define PSP_SRC_A2        8'h04
`define PSP_SRC_RS485     8'h05
`define PSP_SRC_FBUS      8'h07
`define PSP_SRC_USEQ      8'h09
`define PSP_SRC_PULSE     8'h0B
`define PSP_SP_RESET      8'h00
`define PSP_FB_RESET      8'h01
// ********************************************************
// Other codes
// ********************************************************
`define PSP_MON_SP        8'h11
`define PSP_MON_FB        8'h12
`define PSP_MFI_ICLR      8'h15
// ********************************************************
// Scaling, 10000 is 100.00 %
// ********************************************************
`define PSP_FULL          32'sh00002710
`define PSP_A1_FS         32'sh000007FF
`define PSP_A2_VFS        32'sh00000FFF
`define PSP_A2_4MA        32'sh00000333
`define PSP_A2_ISPAN      32'sh00000CCC
`define PSP_PULSE_FULL    32'sh00000C80
`define PSP_P_DIV         32'sh000F4240
`define PSP_VMAX          32'sh00007FFF
`define PSP_VMIN          32'shFFFF8000
`define PSP_ACC_MAX       41'sh07FFFFFFFFF
`define PSP_ACC_MIN       41'sh18000000001
`endif

// *** psp_pkg.sv ***
// Types for the process-loop source select and PI core
package psp_pkg;
  typedef logic signed [15:0] psp_val_t;
  typedef logic        [7:0]  psp_code_t;
  typedef logic signed [39:0] psp_acc_t;
endpackage

// *** psp_src_model.sv ***
// Far-side model: pulse-train pin and link values
`timescale 1ns/1ps
module psp_src_model (
  input  wire logic        clock,
  input  wire logic [7:0]  period,
  output logic             pulse_train_input,
  output psp_pkg::psp_val_t rs485_value,
  output psp_pkg::psp_val_t fieldbus_value,
  output psp_pkg::psp_val_t user_sequence_link
);
  // Known start phase, since the model has no reset of its own
  logic [7:0] cnt_reg = 8'h00;
  assign rs485_value        = 16'sh0BB8;
  assign fieldbus_value     = 16'sh0FA0;
  assign user_sequence_link = 16'sh1388;
  // Period in clocks; scaled with the shortened gate, so rate stays in range
  always_ff @(posedge clock) begin
    if (period == 8'h00) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= (cnt_reg + 8'h01 >= period) ? 8'h00 : cnt_reg + 8'h01;
    end
  end
  // Idle pin stands low, no stray edges
  assign pulse_train_input = (period != 8'h00) && (cnt_reg < (period >> 1));
endmodule
